/* pkg/roc_params.svh */
// Constants for the relay output override control block.
// Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port.
`ifndef ROC_PARAMS_SVH
`define ROC_PARAMS_SVH

`define ROC_NUM_RELAYS     6
`define ROC_NUM_INPUTS     7
`define ROC_HOLD_W         15
`define ROC_TICK_CNT_W     17
`define ROC_CLK_HZ         10000000
`define ROC_TICK_MS        10
`define ROC_TICK_CYCLES    ((`ROC_CLK_HZ / 1000) * `ROC_TICK_MS)
// Hold times in hundredths of a second, as set: 300.00 s and 0.03 s
`define ROC_HOLD_MAX_CS    30000
`define ROC_HOLD_DEF_CS    3
`define ROC_HOLD_MAX_TICKS (`ROC_HOLD_MAX_CS * 10 / `ROC_TICK_MS)
`define ROC_HOLD_DEF_TICKS (`ROC_HOLD_DEF_CS * 10 / `ROC_TICK_MS)

`define ROC_ADDR_W         8
`define ROC_OFS_CTRL       8'h00
`define ROC_OFS_DIS_TIME   8'h04
`define ROC_OFS_FRC_TIME   8'h08
`define ROC_OFS_FRC_SEL    8'h0c
`define ROC_OFS_STATUS     8'h10
`define ROC_OFS_INV_BASE   8'h20

`define ROC_CTRL_DIS_EN    0
`define ROC_CTRL_DIS_MODE  1
`define ROC_CTRL_FRC_MODE  2
`define ROC_ST_DISARMED    0
`define ROC_ST_FORCING     1
`define ROC_ST_DIS_REQ     2
`define ROC_ST_RELAY_LSB   8
`define ROC_ST_SUPERV      15

`define ROC_RESP_OKAY      2'b00
`define ROC_RESP_SLVERR    2'b10

`endif

/* pkg/roc_pkg.sv */
// Types for the relay output override control block.
// Assumes roc_params.svh is on the include path.
`include "roc_params.svh"

package roc_pkg;

	typedef enum logic [1:0] {
		ROC_FORCE_NORMAL = 2'b00,
		ROC_FORCE_ON     = 2'b01,
		ROC_FORCE_OFF    = 2'b10
	} roc_force_e_t;

	typedef enum logic {
		ROC_MODE_PERMANENT = 1'b0,
		ROC_MODE_TIMED     = 1'b1
	} roc_mode_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic [2:0]  awprot;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic [2:0]  arprot;
		logic        rready;
	} roc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} roc_axil_rsp_t;

	typedef logic [`ROC_NUM_RELAYS-1:0][`ROC_NUM_INPUTS-1:0] roc_assign_t;

	typedef struct packed {
		logic                  run;
		logic                  expired;
		logic [`ROC_HOLD_W-1:0] cnt;
	} roc_timer_state_t;

	typedef struct packed {
		logic [`ROC_TICK_CNT_W-1:0]         tick_cnt;
		logic                               tick;
		logic                               aw_full;
		logic [`ROC_ADDR_W-1:0]             aw_addr;
		logic                               w_full;
		logic [31:0]                        w_data;
		logic [3:0]                         w_strb;
		roc_axil_rsp_t                      rsp;
		logic                               dis_en;
		roc_mode_t                          dis_mode;
		roc_mode_t                          frc_mode;
		logic [`ROC_HOLD_W-1:0]             dis_time;
		logic [`ROC_HOLD_W-1:0]             frc_time;
		logic [`ROC_NUM_RELAYS-1:0][1:0]    frc_sel;
		roc_assign_t                        invert;
		logic                               dis_req;
		logic                               dis_req_q;
		logic                               frc_start;
		logic [`ROC_NUM_RELAYS-1:0]         relay;
		logic                               superv;
	} roc_top_state_t;

endpackage : roc_pkg

/* logic/roc_hold_timer.sv */
// Hold timer counted in 10 ms ticks, restartable.
// Assumes i_tick is a one-cycle enable from the tick divider.
`include "roc_params.svh"
module roc_hold_timer
	import roc_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire logic                   i_rst,
	input  wire logic                   i_start,
	input  wire logic                   i_tick,
	input  wire logic [`ROC_HOLD_W-1:0] i_preset,
	output logic                        o_running,
	output logic                        o_expired
);

	roc_timer_state_t s_reg;
	roc_timer_state_t s_next;

	always_comb begin
		s_next         = s_reg;
		s_next.expired = 1'b0;
		if (i_start) begin
			s_next.run = 1'b1;
			s_next.cnt = i_preset;
		end else if (i_tick && s_reg.run) begin
			// Preset of zero or one ends on the first tick
			if (s_reg.cnt <= `ROC_HOLD_W'(1)) begin
				s_next.run     = 1'b0;
				s_next.expired = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt - `ROC_HOLD_W'(1);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_running = s_reg.run;
	assign o_expired = s_reg.expired;

endmodule : roc_hold_timer

/* logic/roc_top.sv */
// Relay output override control for one output card slot.
// Assumes assigned signals, disarm command and supervision come from the same clock domain.
//
// How it works
// - Each assigned relay input has a polarity bit; set means use its complement.
// - Per-slot disarm enable bit, reset inactive, allows or blocks disarming.
// - Outputs are disarmed only when enable and the external disarm step both hold.
// - Disarm mode permanent or timed, reset permanent; permanent holds while condition holds.
// - The supervision contact output is never disarmed or forced.
// - Timed disarm re-arms after hold time, 0 to 300.00 s, default 0.03 s.
// - Forcing applies only while the slot is not disarmed.
// - Each relay is normal, forced energized, or forced de-energized.
// - Force mode permanent or timed, reset permanent.
// - Timed force ignores assigned signals for hold time, then returns to normal.
`include "roc_params.svh"
module roc_top
	import roc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `ROC_TICK_CYCLES
)
(
	input  wire logic                       i_clock,
	input  wire logic                       i_rst,
	input  wire roc_axil_req_t              i_axi,
	output roc_axil_rsp_t                   o_axi,
	input  wire logic                       i_disarm_cmd,
	input  wire roc_assign_t                i_assigned,
	input  wire logic                       i_supervision,
	output logic [`ROC_NUM_RELAYS-1:0]      o_relay,
	output logic                            o_supervision
);

	roc_top_state_t s_reg;
	roc_top_state_t s_next;

	logic dis_run;
	logic dis_expired;
	logic frc_run;
	logic frc_expired;
	logic dis_start;
	logic disarmed;
	logic forcing;

	// Write data merged under byte strobes
	function automatic logic [31:0] roc_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction : roc_merge

	// Out-of-range hold times are clamped to the largest legal setting
	function automatic logic [`ROC_HOLD_W-1:0] roc_clamp(input logic [31:0] v);
		logic [31:0] lim;
		lim = 32'(`ROC_HOLD_MAX_TICKS);
		if (v > lim) begin
			return `ROC_HOLD_W'(lim);
		end
		return v[`ROC_HOLD_W-1:0];
	endfunction : roc_clamp

	function automatic logic roc_mapped(input logic [`ROC_ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		if (a[1:0] == 2'b00) begin
			if (a <= `ROC_OFS_STATUS) begin
				hit = 1'b1;
			end
			if (a >= `ROC_OFS_INV_BASE &&
			    a < `ROC_OFS_INV_BASE + `ROC_ADDR_W'(4 * `ROC_NUM_RELAYS)) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : roc_mapped

	function automatic logic [31:0] roc_read(
		input roc_top_state_t          st,
		input logic [`ROC_ADDR_W-1:0] a,
		input logic                    dis,
		input logic                    frc
	);
		logic [31:0] d;
		logic [`ROC_ADDR_W-1:0] rel;
		d   = 32'h0000_0000;
		rel = a - `ROC_OFS_INV_BASE;
		case (a)
			`ROC_OFS_CTRL: begin
				d[`ROC_CTRL_DIS_EN]   = st.dis_en;
				d[`ROC_CTRL_DIS_MODE] = st.dis_mode;
				d[`ROC_CTRL_FRC_MODE] = st.frc_mode;
			end
			`ROC_OFS_DIS_TIME: d[`ROC_HOLD_W-1:0] = st.dis_time;
			`ROC_OFS_FRC_TIME: d[`ROC_HOLD_W-1:0] = st.frc_time;
			`ROC_OFS_FRC_SEL:  d[2*`ROC_NUM_RELAYS-1:0] = st.frc_sel;
			`ROC_OFS_STATUS: begin
				d[`ROC_ST_DISARMED] = dis;
				d[`ROC_ST_FORCING]  = frc;
				d[`ROC_ST_DIS_REQ]  = st.dis_req;
				d[`ROC_ST_RELAY_LSB +: `ROC_NUM_RELAYS] = st.relay;
				d[`ROC_ST_SUPERV]   = st.superv;
			end
			default: begin
				if (roc_mapped(a) && a >= `ROC_OFS_INV_BASE) begin
					d[`ROC_NUM_INPUTS-1:0] = st.invert[rel[`ROC_ADDR_W-1:2]];
				end
			end
		endcase
		return d;
	endfunction : roc_read

	// Timed disarm starts when both disarm conditions first coincide
	assign dis_start = s_reg.dis_req & ~s_reg.dis_req_q;

	assign disarmed = s_reg.dis_req &
	                  ((s_reg.dis_mode == ROC_MODE_PERMANENT) | dis_run | dis_start);

	assign forcing = ~disarmed &
	                 ((s_reg.frc_mode == ROC_MODE_PERMANENT) | frc_run);

	always_comb begin
		logic                   aw_take;
		logic                   w_take;
		logic                   ar_take;
		logic [31:0]            wval;
		logic [`ROC_ADDR_W-1:0] rel;
		logic [`ROC_ADDR_W-1:0] ra;
		aw_take = 1'b0;
		w_take  = 1'b0;
		ar_take = 1'b0;
		wval    = 32'h0000_0000;
		rel     = '0;
		ra      = '0;
		s_next  = s_reg;

		// Free-running tick divider; the first tick of a hold may come early
		s_next.tick = 1'b0;
		if (s_reg.tick_cnt >= `ROC_TICK_CNT_W'(TICK_CYCLES - 1)) begin
			s_next.tick_cnt = '0;
			s_next.tick     = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + `ROC_TICK_CNT_W'(1);
		end

		s_next.dis_req   = s_reg.dis_en & i_disarm_cmd;
		s_next.dis_req_q = s_reg.dis_req;
		s_next.frc_start = 1'b0;

		// Timed force ends by returning every relay to normal
		if (frc_expired && s_reg.frc_mode == ROC_MODE_TIMED) begin
			s_next.frc_sel = '0;
		end

		// Write address and data are taken independently
		aw_take = i_axi.awvalid & s_reg.rsp.awready;
		w_take  = i_axi.wvalid & s_reg.rsp.wready;
		if (aw_take) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = i_axi.awaddr[`ROC_ADDR_W-1:0];
		end
		if (w_take) begin
			s_next.w_full = 1'b1;
			s_next.w_data = i_axi.wdata;
			s_next.w_strb = i_axi.wstrb;
		end
		if (s_reg.rsp.bvalid && i_axi.bready) begin
			s_next.rsp.bvalid = 1'b0;
		end

		if (s_reg.aw_full && s_reg.w_full && !s_reg.rsp.bvalid) begin
			s_next.aw_full    = 1'b0;
			s_next.w_full     = 1'b0;
			s_next.rsp.bvalid = 1'b1;
			s_next.rsp.bresp  = roc_mapped(s_reg.aw_addr) ? `ROC_RESP_OKAY : `ROC_RESP_SLVERR;
			rel = s_reg.aw_addr - `ROC_OFS_INV_BASE;
			case (s_reg.aw_addr)
				`ROC_OFS_CTRL: begin
					wval = roc_merge({29'h0000_0000, s_reg.frc_mode, s_reg.dis_mode,
					                  s_reg.dis_en}, s_reg.w_data, s_reg.w_strb);
					s_next.dis_en   = wval[`ROC_CTRL_DIS_EN];
					s_next.dis_mode = roc_mode_t'(wval[`ROC_CTRL_DIS_MODE]);
					s_next.frc_mode = roc_mode_t'(wval[`ROC_CTRL_FRC_MODE]);
				end
				`ROC_OFS_DIS_TIME: begin
					wval = roc_merge(32'(s_reg.dis_time), s_reg.w_data, s_reg.w_strb);
					s_next.dis_time = roc_clamp(wval);
				end
				`ROC_OFS_FRC_TIME: begin
					wval = roc_merge(32'(s_reg.frc_time), s_reg.w_data, s_reg.w_strb);
					s_next.frc_time = roc_clamp(wval);
				end
				`ROC_OFS_FRC_SEL: begin
					wval = roc_merge(32'(s_reg.frc_sel), s_reg.w_data, s_reg.w_strb);
					s_next.frc_sel   = wval[2*`ROC_NUM_RELAYS-1:0];
					s_next.frc_start = 1'b1;
				end
				default: begin
					if (roc_mapped(s_reg.aw_addr) && s_reg.aw_addr >= `ROC_OFS_INV_BASE) begin
						wval = roc_merge(32'(s_reg.invert[rel[`ROC_ADDR_W-1:2]]),
						                 s_reg.w_data, s_reg.w_strb);
						s_next.invert[rel[`ROC_ADDR_W-1:2]] = wval[`ROC_NUM_INPUTS-1:0];
					end
				end
			endcase
		end
		// One write in flight: channels reopen only after the response is taken
		s_next.rsp.awready = ~s_next.aw_full & ~s_next.rsp.bvalid;
		s_next.rsp.wready  = ~s_next.w_full & ~s_next.rsp.bvalid;

		// Read: answer one cycle after the address is taken
		ar_take = i_axi.arvalid & s_reg.rsp.arready;
		if (s_reg.rsp.rvalid && i_axi.rready) begin
			s_next.rsp.rvalid = 1'b0;
		end
		if (ar_take) begin
			ra = i_axi.araddr[`ROC_ADDR_W-1:0];
			s_next.rsp.rvalid = 1'b1;
			s_next.rsp.rdata  = roc_read(s_reg, ra, disarmed, forcing);
			s_next.rsp.rresp  = roc_mapped(ra) ? `ROC_RESP_OKAY : `ROC_RESP_SLVERR;
		end
		s_next.rsp.arready = ~s_next.rsp.rvalid;

		// Relay drive: disarm beats force, force beats assigned signals
		for (int k = 0; k < `ROC_NUM_RELAYS; k++) begin
			if (disarmed) begin
				s_next.relay[k] = 1'b0;
			end else if (forcing && s_reg.frc_sel[k] == ROC_FORCE_ON) begin
				s_next.relay[k] = 1'b1;
			end else if (forcing && s_reg.frc_sel[k] == ROC_FORCE_OFF) begin
				s_next.relay[k] = 1'b0;
			end else begin
				s_next.relay[k] = |(i_assigned[k] ^ s_reg.invert[k]);
			end
		end
		// Supervision contact bypasses disarm and force entirely
		s_next.superv = i_supervision;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s_reg             <= '0;
			s_reg.dis_mode    <= ROC_MODE_PERMANENT;
			s_reg.frc_mode    <= ROC_MODE_PERMANENT;
			s_reg.dis_time    <= `ROC_HOLD_W'(`ROC_HOLD_DEF_TICKS);
			s_reg.frc_time    <= `ROC_HOLD_W'(`ROC_HOLD_DEF_TICKS);
			s_reg.rsp.awready <= 1'b1;
			s_reg.rsp.wready  <= 1'b1;
			s_reg.rsp.arready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	roc_hold_timer u_dis_timer (
		.i_clock   (i_clock),
		.i_rst     (i_rst),
		.i_start   (dis_start),
		.i_tick    (s_reg.tick),
		.i_preset  (s_reg.dis_time),
		.o_running (dis_run),
		.o_expired (dis_expired)
	);

	roc_hold_timer u_frc_timer (
		.i_clock   (i_clock),
		.i_rst     (i_rst),
		.i_start   (s_reg.frc_start),
		.i_tick    (s_reg.tick),
		.i_preset  (s_reg.frc_time),
		.o_running (frc_run),
		.o_expired (frc_expired)
	);

	assign o_axi         = s_reg.rsp;
	assign o_relay       = s_reg.relay;
	assign o_supervision = s_reg.superv;

endmodule : roc_top

/* test/roc_prot_model.sv */
// Protection-side model: assigned signals, second disarm step, supervision.
// Assumes the bench hands it the wanted levels; it applies them after the next edge.
module roc_prot_model
	import roc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire roc_assign_t i_pat,
	input  wire logic        i_cmd,
	input  wire logic        i_sup,
	output roc_assign_t      o_assigned,
	output logic             o_disarm_cmd,
	output logic             o_supervision
);
	timeunit 1ns;
	timeprecision 1ns;
	// Levels move only after an edge, like the protection logic in the same domain
	always_ff @(posedge i_clock) begin
		o_assigned    <= i_pat;
		o_disarm_cmd  <= i_cmd;
		o_supervision <= i_sup;
	end
endmodule : roc_prot_model

/* test/roc_top_asserts.sv */
// Checker for the relay override block, watching only its top ports.
// Assumes one clock and the synchronous active-high reset.
`include "roc_params.svh"
module roc_top_asserts
	import roc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 10
)
(
	input wire logic                       i_clock,
	input wire logic                       i_rst,
	input wire roc_axil_req_t              i_axi,
	input wire roc_axil_rsp_t              o_axi,
	input wire logic                       i_disarm_cmd,
	input wire roc_assign_t                i_assigned,
	input wire logic                       i_supervision,
	input wire logic [`ROC_NUM_RELAYS-1:0] o_relay,
	input wire logic                       o_supervision
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	a_superv_copy: assert property (
		!$past(i_rst) |-> o_supervision == $past(i_supervision))
		else $error("supervision output not the input one cycle late");
	a_relay_reset: assert property ($fell(i_rst) |-> o_relay == '0)
		else $error("relays energized right after reset");
	a_read_answer: assert property (
		i_axi.arvalid && o_axi.arready |=> o_axi.rvalid && !o_axi.arready)
		else $error("read answer not one cycle after address");
	a_read_hold: assert property (
		o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
		else $error("read data dropped before taken");
	a_write_answer: assert property (
		i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
		|=> !o_axi.awready ##1 o_axi.bvalid)
		else $error("write response not two cycles after address and data");
	a_write_hold: assert property (
		o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
		else $error("write response dropped before taken");
	a_write_block: assert property (o_axi.bvalid |-> !o_axi.awready && !o_axi.wready)
		else $error("new write accepted while response pending");
	a_ready_back: assert property (
		o_axi.bvalid && i_axi.bready |=> o_axi.awready && o_axi.wready && !o_axi.bvalid)
		else $error("write channel not free after response");
	c_write: cover property (o_axi.bvalid && i_axi.bready);
	c_all_on: cover property (o_relay == '1);
	c_drop: cover property ($fell(|o_relay));
endmodule : roc_top_asserts
bind roc_top roc_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) roc_top_asserts_inst (
	.i_clock(i_clock), .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi),
	.i_disarm_cmd(i_disarm_cmd), .i_assigned(i_assigned), .i_supervision(i_supervision),
	.o_relay(o_relay), .o_supervision(o_supervision));

/* test/tb.sv */
// Self-checking bench for the relay override block.
// Assumes a short tick of 10 clocks; relay states are read back through the status word.
`include "roc_params.svh"
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module tb
	import roc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 10;
	logic                       i_clock = 1'b0;
	logic                       i_rst   = 1'b1;
	roc_axil_req_t              i_axi   = '0;
	roc_axil_rsp_t              o_axi;
	roc_assign_t                pat     = '0;
	roc_assign_t                asg;
	logic                       cmd     = 1'b0;
	logic                       sup     = 1'b0;
	logic                       dcmd, dsup, o_supervision;
	logic [`ROC_NUM_RELAYS-1:0] o_relay;
	logic [65:0]                exq[$];
	logic [65:0]                e;
	logic [6:0]                 inv[6] = '{default: '0};
	logic [31:0]                seed    = 32'h4717a10a;
	int                         miscompares = 0;
	int                         checks_done = 0;

	always #50 i_clock = ~i_clock;

	roc_top #(.TICK_CYCLES(TK)) roc_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_axi(i_axi),
		.o_axi(o_axi), .i_disarm_cmd(dcmd), .i_assigned(asg), .i_supervision(dsup),
		.o_relay(o_relay), .o_supervision(o_supervision));
	roc_prot_model roc_prot_model_inst (.i_clock(i_clock), .i_pat(pat), .i_cmd(cmd),
		.i_sup(sup), .o_assigned(asg), .o_disarm_cmd(dcmd), .o_supervision(dsup));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [5:0] norm();
		for (int k = 0; k < 6; k++) norm[k] = |(pat[k] ^ inv[k]);
	endfunction : norm

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		@(posedge i_clock);
		exq.push_back({32'h0, r, 32'h0});
		i_axi.awaddr  <= {24'h0, a};
		i_axi.wdata   <= d;
		i_axi.wstrb   <= 4'hf;
		i_axi.awvalid <= 1'b1;
		i_axi.wvalid  <= 1'b1;
		i_axi.bready  <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_axi.awready) i_axi.awvalid <= 1'b0;
			if (o_axi.wready) i_axi.wvalid <= 1'b0;
		end while (!o_axi.bvalid);
		i_axi.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hffffffff, input logic [1:0] r = 2'b00);
		@(posedge i_clock);
		exq.push_back({m, r, d & m});
		i_axi.araddr  <= {24'h0, a};
		i_axi.arvalid <= 1'b1;
		i_axi.rready  <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_axi.arready) i_axi.arvalid <= 1'b0;
		end while (!o_axi.rvalid);
		i_axi.rready <= 1'b0;
	endtask : rd

	// Expected relays: disarmed wins over forcing, forcing over the assigned signals
	task automatic st(input logic dis, input logic [5:0] fon = '0, input logic [5:0] foff = '0);
		logic [5:0] rel;
		repeat (3) @(posedge i_clock);
		rel = dis ? 6'h0 : (norm() | fon) & ~foff;
		rd(`ROC_OFS_STATUS, {16'h0, sup, 1'b0, rel, 7'h0, dis}, 32'h0000bf01);
		// Pins checked too, not only their copy in the status word
		`CHK("o_relay", rel, o_relay)
		`CHK("o_supervision", sup, o_supervision)
	endtask : st

	always @(posedge i_clock) begin
		if (!i_rst && ((o_axi.bvalid && i_axi.bready) || (o_axi.rvalid && i_axi.rready))) begin
			e = exq.pop_front();
			if (o_axi.bvalid) `CHK("bresp", e[33:32], o_axi.bresp)
			else `CHK("rdata", e[33:0], {o_axi.rresp, o_axi.rdata & e[65:34]})
		end
	end

	initial begin
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(`ROC_OFS_CTRL, 32'h0);
		rd(`ROC_OFS_DIS_TIME, 32'h3);
		rd(`ROC_OFS_FRC_TIME, 32'h3);
		rd(`ROC_OFS_FRC_SEL, 32'h0);
		for (int k = 0; k < 6; k++) rd(`ROC_OFS_INV_BASE + 8'(4 * k), 32'h0);
		rd(8'h14, 32'h0, 32'hffffffff, `ROC_RESP_SLVERR);
		wr(8'h18, 32'h1, `ROC_RESP_SLVERR);
		wr(`ROC_OFS_DIS_TIME, 32'hffff);
		rd(`ROC_OFS_DIS_TIME, 32'd30000);
		for (int i = 0; i < 12; i++) begin
			inv[i % 6] = 7'(rnd());
			wr(`ROC_OFS_INV_BASE + 8'(4 * (i % 6)), {25'h0, inv[i % 6]});
			pat <= roc_assign_t'({rnd(), rnd()});
			sup <= ^rnd();
			st(1'b0);
		end
		cmd <= 1'b1;
		st(1'b0);
		wr(`ROC_OFS_CTRL, 32'h1);
		st(1'b1);
		wr(`ROC_OFS_FRC_SEL, 32'h939);
		st(1'b1);
		cmd <= 1'b0;
		st(1'b0, 6'h11, 6'h22);
		repeat (6 * TK) @(posedge i_clock);
		st(1'b0, 6'h11, 6'h22);
		wr(`ROC_OFS_FRC_SEL, 32'h0);
		wr(`ROC_OFS_DIS_TIME, 32'h2);
		wr(`ROC_OFS_CTRL, 32'h3);
		cmd <= 1'b1;
		st(1'b1);
		repeat (4 * TK) @(posedge i_clock);
		st(1'b0);
		wr(`ROC_OFS_DIS_TIME, 32'h0);
		cmd <= 1'b0;
		st(1'b0);
		cmd <= 1'b1;
		repeat (2 * TK) @(posedge i_clock);
		st(1'b0);
		cmd <= 1'b0;
		wr(`ROC_OFS_CTRL, 32'h4);
		wr(`ROC_OFS_FRC_SEL, 32'h555);
		st(1'b0, 6'h3f);
		repeat (4 * TK) @(posedge i_clock);
		st(1'b0);
		rd(`ROC_OFS_FRC_SEL, 32'h0);
		// A second reset mid-run must clear both outputs and restore the control word and disarm time
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		`CHK("o_relay", 6'h0, o_relay)
		`CHK("o_supervision", 1'b0, o_supervision)
		i_rst <= 1'b0;
		rd(`ROC_OFS_CTRL, 32'h0);
		rd(`ROC_OFS_DIS_TIME, 32'h3);
		finish_test();
	end

	// A hung handshake would stall the sequence for good
	initial begin
		repeat (20000) @(posedge i_clock);
		miscompares++;
		finish_test();
	end
endmodule : tb
